/* design/tcsc_pkg.sv */
`default_nettype none

package tcsc_pkg;

  // APB address width and register byte offsets
  localparam int unsigned ADDR_W      = 12;
  localparam logic [11:0] OFF_CTRL    = 12'h000;  // clock_select_control
  localparam logic [11:0] OFF_ISTAT   = 12'h004;  // Sticky event status, write one to clear
  localparam logic [11:0] OFF_IMASK   = 12'h008;  // Event enable mask, same layout
  localparam logic [11:0] OFF_STATUS  = 12'h00C;  // Live state, read only

  // Control register fields, bit 7 down to bit 0
  typedef struct packed {
    logic       viol;     // violation_inject_bit
    logic       t1;       // t1_e1_select_bit
    logic       align;    // tx_frame_tick_align
    logic       protect;  // Clock-loss protection enable
    logic [1:0] rsvd;     // Reserved, stored as written
    logic [1:0] src;      // tx_timing_source_sel
  } tcsc_ctrl_t;

  // Protection on, PLL source, all else off
  localparam logic [7:0] CTRL_RESET   = 8'h11;

  // Interrupt status and mask layout
  localparam int unsigned IRQ_W       = 8;
  localparam int unsigned IRQ_VIOL    = 0;  // A violation went out
  localparam int unsigned IRQ_REGAIN  = 4;  // Recovery regained while falling back
  localparam int unsigned IRQ_LOSS    = 5;  // Clock loss seen with protection on
  localparam logic [7:0]  IMASK_RESET = 8'h00;
  localparam logic [7:0]  ISTAT_RESET = 8'h00;

  // Live status layout
  localparam int unsigned ST_FALLBACK = 0;  // Running on PLL because of loss
  localparam int unsigned ST_LOST     = 1;  // Synchronised loss input
  localparam int unsigned ST_SRC_LSB  = 2;  // Effective source, two bits

  // Timing source codes
  typedef enum logic [1:0] {
    SRC_RECOVERED = 2'b00,  // Recovered line clock
    SRC_PLL       = 2'b01,  // Master-clock PLL
    SRC_TX_SERIAL = 2'b10,  // Transmit serial clock input
    SRC_TX_AUX    = 2'b11   // Auxiliary transmit clock input
  } tcsc_src_t;

  // Transmit framer control carrier
  typedef struct packed {
    logic      t1_mode;   // 1 selects T1 framing
    tcsc_src_t src;       // Effective timing source
    logic      fallback;  // Substituted PLL for lost recovery
  } tcsc_tx_ctl_t;

  // Frame tick period and its length in clock cycles
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned TICK_PERIOD_NS = 125000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

endpackage

`default_nettype wire

/* design/tcsc_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module tcsc_sync (
  input  wire logic       pclk,     // System clock
  input  wire logic       presetn,  // Async reset, active low
  input  wire logic [1:0] async_in, // Levels from outside this domain
  output logic      [1:0] sync_out  // Two-stage synchronised levels
);

  logic [1:0] stage1;  // Metastability catcher, read only by stage two

  // Two flops per bit, one generate branch each
  for (genvar i = 0; i < 2; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stage1[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        stage1[i]   <= async_in[i];
        sync_out[i] <= stage1[i];
      end
    end
  end

endmodule

`default_nettype wire

/* design/tcsc_fallback.sv */
`timescale 1ns/1ps
`default_nettype none

module tcsc_fallback (
  input  wire logic               pclk,      // System clock
  input  wire logic               presetn,   // Async reset, active low
  input  wire logic               protect,   // Protection enable
  input  wire tcsc_pkg::tcsc_src_t sel_src,  // Software-selected source
  input  wire logic               lost,      // Synchronised loss of recovery
  output tcsc_pkg::tcsc_src_t     eff_src,   // Source actually used
  output logic                    active,    // Fallback in force
  output logic                    loss_evt,  // One-cycle loss event
  output logic                    regain_evt // One-cycle regain event
);

  typedef enum logic {
    FB_NORMAL = 1'b0,  // Selected source in use
    FB_PLL    = 1'b1   // Substituting PLL clock
  } tcsc_fb_state_t;

  tcsc_fb_state_t state;      // Current fallback state
  tcsc_fb_state_t next_state; // Next fallback state
  logic           lost_d;     // Previous loss level for edge detect

  // Only a protected, recovered-clock channel may fall back
  always_comb begin
    next_state = state;
    unique case (state)
      FB_NORMAL: if (protect && sel_src == tcsc_pkg::SRC_RECOVERED && lost)
                   next_state = FB_PLL;
      FB_PLL:    if (!lost || !protect || sel_src != tcsc_pkg::SRC_RECOVERED)
                   next_state = FB_NORMAL;
    endcase
  end

  // State, effective source and events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= FB_NORMAL;
      lost_d     <= 1'b0;
      eff_src    <= tcsc_pkg::SRC_PLL;
      active     <= 1'b0;
      loss_evt   <= 1'b0;
      regain_evt <= 1'b0;
    end else begin
      state      <= next_state;
      lost_d     <= lost;
      active     <= (next_state == FB_PLL);
      eff_src    <= (next_state == FB_PLL) ? tcsc_pkg::SRC_PLL : sel_src;
      // Loss reported only while protection is on
      loss_evt   <= lost && !lost_d && protect;
      regain_evt <= (state == FB_PLL) && !lost;
    end
  end

endmodule

`default_nettype wire

/* design/tcsc_top.sv */
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module tcsc_top (
  input  wire logic                 pclk,          // System clock, 25 MHz
  input  wire logic                 presetn,       // Async reset, active low
  input  wire logic                 psel,          // APB select
  input  wire logic                 penable,       // APB access phase
  input  wire logic                 pwrite,        // APB write
  input  wire logic [11:0]          paddr,         // APB byte address
  input  wire logic [31:0]          pwdata,        // APB write data
  output logic      [31:0]          prdata,        // APB read data
  output logic                      pready,        // APB ready
  output logic                      pslverr,       // APB error, unmapped
  input  wire logic                 recovery_lost, // Line interface lost clock recovery
  input  wire logic                 pll_tick_8k,   // Frame tick from PLL
  output tcsc_pkg::tcsc_tx_ctl_t    tx_ctl,        // Mode and timing to framer
  output logic                      line_code_violation, // Inject one violation
  output logic                      tx_frame_align,      // Align frame to tick
  output logic                      irq            // Level interrupt
);

  // Register storage
  tcsc_pkg::tcsc_ctrl_t ctrl;        // clock_select_control
  logic [7:0]           istat;       // Sticky events
  logic [7:0]           imask;       // Event enables
  logic [7:0]           ev_set;      // Events raised this cycle
  logic [7:0]           ev_clr;      // Write-one-to-clear bits

  // Bus phase decode
  logic                 setup_ph;    // Setup cycle
  logic                 wr_fire;     // Write takes effect now
  logic                 mapped;      // Address hits a register

  // Synchronised pins and derived levels
  logic [1:0]           sync_lvl;    // {tick, lost} after two flops
  logic                 lost_s;      // Loss of recovery, synced
  logic                 tick_s;      // Frame tick, synced
  logic                 tick_d;      // Tick delayed for edge detect
  logic                 viol_d;      // Violation bit last cycle

  // Fallback results
  tcsc_pkg::tcsc_src_t  eff_src;     // Source in use
  logic                 fb_active;   // Fallback in force
  logic                 loss_evt;    // Loss event
  logic                 regain_evt;  // Regain event

  // Address decode shared by error answer and the unmapped-error check
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == tcsc_pkg::OFF_CTRL)  || (a == tcsc_pkg::OFF_ISTAT) ||
                (a == tcsc_pkg::OFF_IMASK) || (a == tcsc_pkg::OFF_STATUS);
  endfunction

  assign setup_ph = psel && !penable;
  assign wr_fire  = psel && penable && pready && pwrite;
  assign mapped   = is_mapped(paddr);
  assign lost_s   = sync_lvl[0];
  assign tick_s   = sync_lvl[1];

  // Both pins come from other domains
  tcsc_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({pll_tick_8k, recovery_lost}),
    .sync_out (sync_lvl)
  );

  // Clock-loss fallback
  tcsc_fallback u_fb (
    .pclk       (pclk),
    .presetn    (presetn),
    .protect    (ctrl.protect),
    .sel_src    (tcsc_pkg::tcsc_src_t'(ctrl.src)),
    .lost       (lost_s),
    .eff_src    (eff_src),
    .active     (fb_active),
    .loss_evt   (loss_evt),
    .regain_evt (regain_evt)
  );

  // Ready one cycle after setup: every transfer has one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph && !mapped;  // Unmapped answers with error
    end
  end

  // Read data captured in setup; stale by one cycle at most
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      unique case (paddr)
        tcsc_pkg::OFF_CTRL:   prdata <= {24'h00_0000, ctrl};
        tcsc_pkg::OFF_ISTAT:  prdata <= {24'h00_0000, istat};
        tcsc_pkg::OFF_IMASK:  prdata <= {24'h00_0000, imask};
        tcsc_pkg::OFF_STATUS: prdata <= {28'h000_0000, eff_src, lost_s, fb_active};
        default:              prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control register; reserved bits stored as software writes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= tcsc_pkg::CTRL_RESET;
    end else if (wr_fire && paddr == tcsc_pkg::OFF_CTRL) begin
      ctrl <= pwdata[7:0];
    end
  end

  // Mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask <= tcsc_pkg::IMASK_RESET;
    end else if (wr_fire && paddr == tcsc_pkg::OFF_IMASK) begin
      imask <= pwdata[7:0];
    end
  end

  // Event collection into status layout
  always_comb begin
    ev_set                       = 8'h00;
    ev_set[tcsc_pkg::IRQ_VIOL]   = line_code_violation;
    ev_set[tcsc_pkg::IRQ_REGAIN] = regain_evt;
    ev_set[tcsc_pkg::IRQ_LOSS]   = loss_evt;
    ev_clr = (wr_fire && paddr == tcsc_pkg::OFF_ISTAT) ? pwdata[7:0] : 8'h00;
  end

  // Sticky status; a set in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat <= tcsc_pkg::ISTAT_RESET;
    end else begin
      istat <= (istat & ~ev_clr) | ev_set;
    end
  end

  // Interrupt level from unmasked status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat & imask);
    end
  end

  // Violation injection on zero-to-one of the control bit only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      viol_d              <= 1'b0;
      line_code_violation <= 1'b0;
    end else begin
      viol_d              <= ctrl.viol;
      line_code_violation <= ctrl.viol && !viol_d;
    end
  end

  // Frame alignment: tick edge gated by enable and PLL selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_d         <= 1'b0;
      tx_frame_align <= 1'b0;
    end else begin
      tick_d         <= tick_s;
      // Selected source decides; a fallback to PLL does not enable it
      tx_frame_align <= tick_s && !tick_d && ctrl.align &&
                        (ctrl.src == tcsc_pkg::SRC_PLL);
    end
  end

  // Per-channel framer controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ctl <= '{t1_mode: 1'b0, src: tcsc_pkg::SRC_PLL, fallback: 1'b0};
    end else begin
      tx_ctl.t1_mode  <= ctrl.t1;
      tx_ctl.src      <= eff_src;
      tx_ctl.fallback <= fb_active;
    end
  end

  // Checks on the block's own outputs and internal registers
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_viol_rise;
    $rose(ctrl.viol) |=> line_code_violation;
  endproperty
  a_viol_rise: assert property (p_viol_rise) else $error("violation not injected");

  property p_viol_single;
    line_code_violation |=> !line_code_violation [*2];
  endproperty
  a_viol_single: assert property (p_viol_single) else $error("violation repeated");

  property p_mode;
    $changed(ctrl.t1) |=> tx_ctl.t1_mode == $past(ctrl.t1);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not passed on");

  property p_align_off;
    !ctrl.align |=> !tx_frame_align;
  endproperty
  a_align_off: assert property (p_align_off) else $error("align while disabled");

  property p_align_src;
    (ctrl.src != tcsc_pkg::SRC_PLL) |=> !tx_frame_align;
  endproperty
  a_align_src: assert property (p_align_src) else $error("align without PLL");

  property p_src_write;
    (wr_fire && paddr == tcsc_pkg::OFF_CTRL) |=> ctrl.src == $past(pwdata[1:0]);
  endproperty
  a_src_write: assert property (p_src_write) else $error("source not stored");

  property p_fallback;
    (ctrl.protect && ctrl.src == tcsc_pkg::SRC_RECOVERED && lost_s) [*3]
      |-> tx_ctl.src == tcsc_pkg::SRC_PLL;
  endproperty
  a_fallback: assert property (p_fallback) else $error("no fallback to PLL");

  property p_no_protect;
    !ctrl.protect |=> !fb_active;
  endproperty
  a_no_protect: assert property (p_no_protect) else $error("fallback while off");

  property p_loss_flag;
    $rose(istat[tcsc_pkg::IRQ_LOSS]) |-> $past(ctrl.protect, 2);
  endproperty
  a_loss_flag: assert property (p_loss_flag) else $error("loss flag unprotected");

  property p_irq;
    (|(istat & imask)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  // Bus answer checks and control register hold
  property p_ready_after_setup;
    (psel && !penable) |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("ready late");

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");

  property p_unmapped_err;
    (psel && !penable && !is_mapped(paddr)) |=> pslverr && pready;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped without error");

  property p_ctrl_hold;
    !(wr_fire && paddr == tcsc_pkg::OFF_CTRL) |=> $stable(ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed unwritten");

  // Line-side checks
  property p_viol_steady;
    $stable(ctrl.viol) |=> !line_code_violation;
  endproperty
  a_viol_steady: assert property (p_viol_steady) else $error("violation while steady");

  property p_align_single;
    tx_frame_align |=> !tx_frame_align [*2];
  endproperty
  a_align_single: assert property (p_align_single) else $error("align repeated");

  // Fallback and event checks
  property p_fb_src;
    fb_active |-> eff_src == tcsc_pkg::SRC_PLL;
  endproperty
  a_fb_src: assert property (p_fb_src) else $error("fallback without PLL");

  property p_fb_out;
    tx_ctl.fallback |-> tx_ctl.src == tcsc_pkg::SRC_PLL;
  endproperty
  a_fb_out: assert property (p_fb_out) else $error("framer fallback without PLL");

  property p_fb_return;
    (fb_active && !lost_s) |=> !fb_active;
  endproperty
  a_fb_return: assert property (p_fb_return) else $error("no return after regain");

  property p_loss_gate;
    loss_evt |-> $past(ctrl.protect);
  endproperty
  a_loss_gate: assert property (p_loss_gate) else $error("loss event unprotected");

  property p_loss_sticky;
    (istat[tcsc_pkg::IRQ_LOSS] && !ev_clr[tcsc_pkg::IRQ_LOSS]) |=> istat[tcsc_pkg::IRQ_LOSS];
  endproperty
  a_loss_sticky: assert property (p_loss_sticky) else $error("loss flag dropped");

  property p_irq_low;
    !(|(istat & imask)) |=> !irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt without cause");

endmodule

`default_nettype wire

/* test/tcsc_liu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module tcsc_liu_model (
  input  wire logic pclk,          // System clock
  input  wire logic presetn,       // Async reset, active low
  input  wire logic lose_cmd,      // Bench asks for loss of recovery
  input  wire logic tick_en,       // Bench lets the tick run
  output logic      recovery_lost, // Loss of clock recovery level
  output logic      pll_tick_8k    // Frame tick, high four cycles
);
  int cnt;  // Position inside one tick period

  // Free running period counter, 8 kHz at this clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
    end else begin
      cnt <= (cnt == tcsc_pkg::TICK_CYCLES - 1) ? 0 : cnt + 1;
    end
  end

  // Pin levels change only after an edge, like the real line side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recovery_lost <= 1'b0;
      pll_tick_8k   <= 1'b0;
    end else begin
      recovery_lost <= lose_cmd;
      pll_tick_8k   <= tick_en && (cnt < 4);  // Wide pulse survives the synchroniser
    end
  end
endmodule

`default_nettype wire

/* test/tx_clock_select_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tx_clock_select_control_tb;
  logic        pclk, presetn, psel, penable, pwrite;  // Bus side
  logic [11:0] paddr;                                 // Byte address
  logic [31:0] pwdata, prdata, rd;                    // Data, rd holds last read
  logic        pready, pslverr, rerr, irq;            // Answers
  logic        lose, tick_en, viol, align_p;          // Line side
  logic        recovery_lost, pll_tick_8k;            // Model pins
  logic [1:0]  s;                                     // Source under test
  logic        t;                                     // Mode under test
  tcsc_pkg::tcsc_tx_ctl_t tx_ctl;                     // Framer control
  int          fails = 0, total_checks = 0, seed, i;  // Bookkeeping
  int          nviol = 0, nalign = 0, base;           // Pulse counters

  tcsc_top i_tcsc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .recovery_lost(recovery_lost), .pll_tick_8k(pll_tick_8k),
    .tx_ctl(tx_ctl), .line_code_violation(viol), .tx_frame_align(align_p), .irq(irq));

  tcsc_liu_model i_tcsc_liu_model (.pclk(pclk), .presetn(presetn), .lose_cmd(lose),
    .tick_en(tick_en), .recovery_lost(recovery_lost), .pll_tick_8k(pll_tick_8k));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Count one-cycle pulses so bursts and misses both show
  always @(posedge pclk) begin
    if (viol === 1'b1) nviol <= nviol + 1;
    if (align_p === 1'b1) nalign <= nalign + 1;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One bus transfer; waits for pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n == 16) begin
      fails++;
      close_out();
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Control word; reserved bits always written as zero
  function logic [31:0] cfg(logic v, logic m, logic al, logic pr, logic [1:0] src);
    return {24'h0, v, m, al, pr, 2'b00, src};
  endfunction

  // Expected framer control word
  function logic [31:0] exp_tx(logic m, logic [1:0] src, logic fb);
    return {28'h0, m, src, fb};
  endfunction

  initial begin
    seed = 26; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; lose = 1'b0; tick_en = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped place
    rdchk(tcsc_pkg::OFF_CTRL, 32'h11);
    chk(32'(tx_ctl), exp_tx(1'b0, tcsc_pkg::SRC_PLL, 1'b0));
    rdchk(tcsc_pkg::OFF_ISTAT, 32'h0);
    rdchk(tcsc_pkg::OFF_IMASK, 32'h0);
    apb(1'b0, 12'h010, 32'hFFFFFFFF);
    chk({31'h0, rerr}, 32'h1);
    chk(rd, 32'h0);
    // Every source code, then random ones, with random mode
    for (i = 0; i < 10; i++) begin
      t = 1'($random(seed));
      s = (i < 4) ? i[1:0] : 2'($random(seed));
      wr(tcsc_pkg::OFF_CTRL, cfg(1'b0, t, 1'b0, 1'b1, s));
      repeat (3) @(posedge pclk);
      chk(32'(tx_ctl), exp_tx(t, s, 1'b0));
      rdchk(tcsc_pkg::OFF_CTRL, cfg(1'b0, t, 1'b0, 1'b1, s));
    end
    // Rising violation bit, then held high: one pulse only
    wr(tcsc_pkg::OFF_IMASK, 32'h31);
    wr(tcsc_pkg::OFF_CTRL, cfg(1'b0, 1'b0, 1'b0, 1'b1, tcsc_pkg::SRC_PLL));
    base = nviol;
    wr(tcsc_pkg::OFF_CTRL, cfg(1'b1, 1'b0, 1'b0, 1'b1, tcsc_pkg::SRC_PLL));
    wr(tcsc_pkg::OFF_CTRL, cfg(1'b1, 1'b1, 1'b0, 1'b1, tcsc_pkg::SRC_PLL));
    repeat (4) @(posedge pclk);
    chk(nviol - base, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdchk(tcsc_pkg::OFF_ISTAT, 32'h1);
    wr(tcsc_pkg::OFF_IMASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(tcsc_pkg::OFF_ISTAT, 32'h1);
    rdchk(tcsc_pkg::OFF_ISTAT, 32'h0);
    wr(tcsc_pkg::OFF_IMASK, 32'h31);
    // Alignment on with PLL, off with PLL, on with recovered source
    tick_en <= 1'b1;
    for (i = 0; i < 3; i++) begin
      wr(tcsc_pkg::OFF_CTRL, cfg(1'b0, 1'b0, i != 1, 1'b1,
         (i == 2) ? tcsc_pkg::SRC_RECOVERED : tcsc_pkg::SRC_PLL));
      repeat (8) @(posedge pclk);
      base = nalign;
      repeat (tcsc_pkg::TICK_CYCLES) @(posedge pclk);
      chk(nalign - base, (i == 0) ? 32'h1 : 32'h0);
    end
    // Loss of recovery with protection on: fall back, then return
    wr(tcsc_pkg::OFF_CTRL, cfg(1'b0, 1'b0, 1'b0, 1'b1, tcsc_pkg::SRC_RECOVERED));
    lose <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(32'(tx_ctl), exp_tx(1'b0, tcsc_pkg::SRC_PLL, 1'b1));
    chk({31'h0, irq}, 32'h1);
    rdchk(tcsc_pkg::OFF_ISTAT, 32'h20);
    rdchk(tcsc_pkg::OFF_STATUS, 32'h7);
    lose <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(32'(tx_ctl), exp_tx(1'b0, tcsc_pkg::SRC_RECOVERED, 1'b0));
    rdchk(tcsc_pkg::OFF_ISTAT, 32'h30);
    rdchk(tcsc_pkg::OFF_STATUS, 32'h0);
    wr(tcsc_pkg::OFF_ISTAT, 32'h30);
    // Protection off: no fallback and no loss flag
    wr(tcsc_pkg::OFF_CTRL, cfg(1'b0, 1'b0, 1'b0, 1'b0, tcsc_pkg::SRC_RECOVERED));
    lose <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(32'(tx_ctl), exp_tx(1'b0, tcsc_pkg::SRC_RECOVERED, 1'b0));
    rdchk(tcsc_pkg::OFF_ISTAT, 32'h0);
    rdchk(tcsc_pkg::OFF_STATUS, 32'h2);
    lose <= 1'b0;
    // Second reset in mid-run brings protection back
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(tcsc_pkg::OFF_CTRL, 32'h11);
    close_out();
  end
endmodule

`default_nettype wire
